// ==== shared/lsn_pkg.sv ====
`default_nettype none
package lsn_pkg;

    localparam int         LSN_SPEED_W       = 4;
    typedef logic [LSN_SPEED_W-1:0] lsn_speed_t;

    // Link speed codes as reported in the current speed field
    localparam lsn_speed_t LSN_SPEED_GEN1    = 4'h1;
    localparam lsn_speed_t LSN_SPEED_GEN2    = 4'h2;

    // Reset values
    localparam lsn_speed_t LSN_TARGET_RESET  = LSN_SPEED_GEN2;
    localparam lsn_speed_t LSN_CURRENT_RESET = LSN_SPEED_GEN1;
    localparam logic       LSN_HW_AUTONOMOUS_SPEED_DISABLE_RESET    = 1'b0;
    localparam logic       LSN_IRQ_EN_RESET  = 1'b0;

    // Configuration access; wr_ctrl loads target, hw_autonomous_speed_disable and irq enable
    typedef struct packed {
        logic       wr_ctrl;
        lsn_speed_t target_speed;
        logic       hw_autonomous_speed_disable;
        logic       bw_mgmt_irq_enable;
        logic       retrain_request;
        logic       clr_bw_mgmt;
        logic       clr_autonomous_bw;
    } lsn_cfg_t;

    typedef struct packed {
        lsn_speed_t current_speed;
        lsn_speed_t target_speed;
        logic       hw_autonomous_speed_disable;
        logic       bw_mgmt_irq_enable;
        logic       bw_mgmt_status;
        logic       autonomous_bw_status;
    } lsn_status_t;

    typedef enum logic [2:0] {
        LSN_ST_TRAIN  = 3'h1,
        LSN_ST_L0     = 3'h2,
        LSN_ST_CHANGE = 3'h4
    } lsn_state_t;

    typedef enum logic [3:0] {
        LSN_CAUSE_INIT    = 4'h1,
        LSN_CAUSE_SW      = 4'h2,
        LSN_CAUSE_PARTNER = 4'h4,
        LSN_CAUSE_RELIAB  = 4'h8
    } lsn_cause_t;

endpackage
`default_nettype wire

// ==== core/lsn_core.sv ====
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// RULE1 - All lanes of the link always run at one common rate.
// RULE2 - Full training always starts the link at the lower rate.
// RULE3 - Upgrade only from L0 and only when both sides offer the rate.
// RULE4 - A rate change never signals data link down.
// RULE5 - Keep link at target speed or highest common supported rate.
// RULE6 - Start a change only when partner is known to support target.
// RULE7 - With one side offering Gen2 only, stay at Gen1.
// RULE8 - Reach Gen2 only through the Recovery.Speed change sequence.
// RULE9 - Target speed resets to higher rate; advertise it in training.
// RULE10 - After reset train at Gen1, then upgrade itself regardless of hw_autonomous_speed_disable.
// RULE11 - Initial upgrade never sets the bandwidth management status bit.
// RULE12 - Current speed field always shows the running link rate.
// RULE13 - Failed upgrade returns to lower rate, no own retry.
// RULE14 - After failure still honour partner and software upgrades.
// RULE15 - Never change speed autonomously; autonomous change bit sent zero.
// RULE16 - Partner autonomous speed change sets autonomous bandwidth status.
// RULE17 - Software writes target speed first, then requests retrain.
// RULE18 - Bandwidth notification only when its interrupt enable is set.
// RULE19 - Reliability or software speed changes set bandwidth status bit.
// RULE20 - hw_autonomous_speed_disable has no effect on software directed speed changes.
// RULE21 - Fixed speed from power-up: load target, then full retrain.
// RULE22 - Status bit becoming set with enable sends an interrupt.
// RULE23 - Both status bits stay set until software writes one.
module lsn_core #(
    parameter int LANES           = 4,
    parameter bit DOWNSTREAM_PORT = 1'b1
) (
    input  wire logic                 CLOCK,
    input  wire logic                 ARST_N,
    input  wire logic                 CE,
    input  wire logic                 FULL_RETRAIN,
    input  wire logic                 LTSSM_L0,
    input  wire logic                 PARTNER_GEN2_ADV,
    input  wire logic                 PARTNER_REQ,
    input  wire lsn_pkg::lsn_speed_t  PARTNER_REQ_SPEED,
    input  wire logic                 PARTNER_AUTONOMOUS,
    input  wire logic                 SPEED_CHANGE_DONE,
    input  wire logic                 SPEED_CHANGE_OK,
    input  wire logic                 RELIABILITY_DOWNGRADE,
    input  wire lsn_pkg::lsn_cfg_t    CFG,
    output logic                      SPEED_CHANGE_START,
    output lsn_pkg::lsn_speed_t       CHANGE_SPEED,
    output logic                      ADV_GEN2,
    output logic                      AUTONOMOUS_CHANGE,
    output logic [LANES*lsn_pkg::LSN_SPEED_W-1:0] LANE_RATE,
    output logic                      DL_DOWN,
    output logic                      BW_IRQ,
    output lsn_pkg::lsn_status_t      STATUS
);
    import lsn_pkg::*;

    initial begin
        if (LANES < 1 || LANES > 32) begin
            $error("lsn_core: LANES out of range");
        end
    end

    lsn_state_t state_reg;
    lsn_cause_t cause_reg;
    lsn_speed_t current_speed_reg;
    lsn_speed_t target_speed_reg;
    lsn_speed_t change_speed_reg;
    logic       hw_autonomous_speed_disable_reg;
    logic       irq_en_reg;
    logic       init_pending_reg;
    logic       failed_reg;
    logic       rel_down_reg;
    logic       sw_pending_reg;
    logic       partner_auto_reg;
    logic       bw_reg;
    logic       abw_reg;
    logic       start_reg;
    logic       dl_down_reg;
    logic       irq_reg;

    logic       adv_gen2;
    logic       partner_up_ok;
    logic       in_l0;
    logic       sw_pending;
    logic       rel_pending;
    logic       start_next;
    lsn_speed_t speed_next;
    lsn_cause_t cause_next;
    logic       change_ok;
    logic       change_fail;
    logic       bw_set;
    logic       abw_set;

    // Lost reliability keeps Gen2 off the advertisement
    assign adv_gen2      = (target_speed_reg == LSN_SPEED_GEN2)
                           && !rel_down_reg;                    // RULE9
    assign partner_up_ok = adv_gen2 && PARTNER_GEN2_ADV;        // RULE6
    assign in_l0         = (state_reg == LSN_ST_L0) && LTSSM_L0; // RULE3
    assign sw_pending    = sw_pending_reg || CFG.retrain_request;
    assign rel_pending   = rel_down_reg || RELIABILITY_DOWNGRADE;
    assign change_ok     = (state_reg == LSN_ST_CHANGE)
                           && SPEED_CHANGE_DONE && SPEED_CHANGE_OK;
    assign change_fail   = (state_reg == LSN_ST_CHANGE)
                           && SPEED_CHANGE_DONE && !SPEED_CHANGE_OK;

    // Decide whether and why a rate change starts; hw_autonomous_speed_disable is never consulted
    always_comb begin
        start_next = 1'b0;
        speed_next = current_speed_reg;
        cause_next = LSN_CAUSE_INIT;
        if (in_l0 && !FULL_RETRAIN) begin
            if (rel_pending && current_speed_reg == LSN_SPEED_GEN2) begin
                start_next = 1'b1;
                speed_next = LSN_SPEED_GEN1;
                cause_next = LSN_CAUSE_RELIAB;
            end else if (sw_pending
                         && target_speed_reg != current_speed_reg
                         && (target_speed_reg == LSN_SPEED_GEN1
                             || partner_up_ok)) begin  // RULE5 RULE20
                start_next = 1'b1;
                speed_next = target_speed_reg;
                cause_next = LSN_CAUSE_SW;
            end else if (PARTNER_REQ
                         && PARTNER_REQ_SPEED != current_speed_reg
                         && (PARTNER_REQ_SPEED == LSN_SPEED_GEN1
                             || partner_up_ok)) begin  // RULE7 RULE14
                start_next = 1'b1;
                speed_next = PARTNER_REQ_SPEED;
                cause_next = LSN_CAUSE_PARTNER;
            end else if (init_pending_reg && !failed_reg
                         && current_speed_reg == LSN_SPEED_GEN1
                         && partner_up_ok) begin       // RULE10 RULE13
                start_next = 1'b1;
                speed_next = LSN_SPEED_GEN2;
                cause_next = LSN_CAUSE_INIT;
            end
        end
    end

    // Link state; Gen2 is reached only via the Recovery.Speed handshake
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            state_reg <= LSN_ST_TRAIN;
        end else if (CE) begin
            if (FULL_RETRAIN) begin
                state_reg <= LSN_ST_TRAIN;
            end else begin
                unique case (state_reg)
                    LSN_ST_TRAIN: begin
                        if (LTSSM_L0) begin
                            state_reg <= LSN_ST_L0;
                        end
                    end
                    LSN_ST_L0: begin
                        if (start_next) begin
                            state_reg <= LSN_ST_CHANGE; // RULE8
                        end
                    end
                    LSN_ST_CHANGE: begin
                        if (SPEED_CHANGE_DONE) begin
                            state_reg <= LSN_ST_L0;
                        end
                    end
                    default: state_reg <= LSN_ST_TRAIN;
                endcase
            end
        end
    end

    // Running rate; a failed attempt leaves the old rate in place
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            current_speed_reg <= LSN_CURRENT_RESET;
        end else if (CE) begin
            if (FULL_RETRAIN) begin
                current_speed_reg <= LSN_SPEED_GEN1;       // RULE2
            end else if (change_ok) begin
                current_speed_reg <= change_speed_reg;     // RULE12
            end
        end
    end

    // Change request towards the LTSSM
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            start_reg        <= 1'b0;
            change_speed_reg <= LSN_CURRENT_RESET;
            cause_reg        <= LSN_CAUSE_INIT;
            partner_auto_reg <= 1'b0;
        end else if (CE) begin
            start_reg <= start_next;
            if (start_next) begin
                change_speed_reg <= speed_next;
                cause_reg        <= cause_next;
                partner_auto_reg <= PARTNER_AUTONOMOUS;
            end
        end
    end

    // Software control fields; loaded only by CFG.wr_ctrl writes
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            target_speed_reg <= LSN_TARGET_RESET;          // RULE9
            hw_autonomous_speed_disable_reg         <= LSN_HW_AUTONOMOUS_SPEED_DISABLE_RESET;
            irq_en_reg       <= LSN_IRQ_EN_RESET;
        end else if (CE && CFG.wr_ctrl) begin              // RULE17 RULE21
            target_speed_reg <= CFG.target_speed;
            hw_autonomous_speed_disable_reg         <= CFG.hw_autonomous_speed_disable;
            irq_en_reg       <= CFG.bw_mgmt_irq_enable;
        end
    end

    // Upgrade bookkeeping
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            init_pending_reg <= 1'b1;
            failed_reg       <= 1'b0;
            rel_down_reg     <= 1'b0;
            sw_pending_reg   <= 1'b0;
        end else if (CE) begin
            if (FULL_RETRAIN) begin
                init_pending_reg <= 1'b1;
                failed_reg       <= 1'b0;
                rel_down_reg     <= 1'b0;
                sw_pending_reg   <= 1'b0;
            end else begin
                if (start_next || current_speed_reg == LSN_SPEED_GEN2) begin
                    init_pending_reg <= 1'b0;
                end
                if (change_fail && change_speed_reg == LSN_SPEED_GEN2) begin
                    failed_reg <= 1'b1;                    // RULE13
                end
                if (RELIABILITY_DOWNGRADE) begin
                    rel_down_reg <= 1'b1;
                end else if (CFG.retrain_request
                             && target_speed_reg == LSN_SPEED_GEN2) begin
                    rel_down_reg <= 1'b0;
                end
                // A retrain with nothing to change is consumed in L0
                if (in_l0 && cause_next != LSN_CAUSE_RELIAB) begin
                    sw_pending_reg <= 1'b0;
                end else if (CFG.retrain_request) begin
                    sw_pending_reg <= 1'b1;
                end
            end
        end
    end

    // Status events; initial upgrade is not a managed change
    assign bw_set  = DOWNSTREAM_PORT && change_ok && !FULL_RETRAIN
                     && (cause_reg == LSN_CAUSE_SW
                         || cause_reg == LSN_CAUSE_RELIAB); // RULE11 RULE19
    assign abw_set = DOWNSTREAM_PORT && change_ok && !FULL_RETRAIN
                     && cause_reg == LSN_CAUSE_PARTNER
                     && partner_auto_reg;                   // RULE16

    // Sticky; a set in the clearing cycle wins
    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            bw_reg  <= 1'b0;
            abw_reg <= 1'b0;
        end else if (CE) begin
            bw_reg  <= bw_set  || (bw_reg  && !CFG.clr_bw_mgmt);      // RULE23
            abw_reg <= abw_set || (abw_reg && !CFG.clr_autonomous_bw); // RULE23
        end
    end

    always_ff @(posedge CLOCK or negedge ARST_N) begin
        if (!ARST_N) begin
            irq_reg     <= 1'b0;
            dl_down_reg <= 1'b0;
        end else if (CE) begin
            irq_reg     <= bw_set && !bw_reg && irq_en_reg; // RULE18 RULE22
            dl_down_reg <= FULL_RETRAIN;                    // RULE4
        end
    end

    assign SPEED_CHANGE_START = start_reg;
    assign CHANGE_SPEED       = change_speed_reg;
    assign ADV_GEN2           = adv_gen2;
    assign AUTONOMOUS_CHANGE  = 1'b0;                       // RULE15
    assign LANE_RATE          = {LANES{current_speed_reg}}; // RULE1
    assign DL_DOWN            = dl_down_reg;
    assign BW_IRQ             = irq_reg;
    assign STATUS             = '{current_speed: current_speed_reg,
                                  target_speed: target_speed_reg,
                                  hw_autonomous_speed_disable: hw_autonomous_speed_disable_reg,
                                  bw_mgmt_irq_enable: irq_en_reg,
                                  bw_mgmt_status: bw_reg,
                                  autonomous_bw_status: abw_reg};

    sequence seq_change_ok;
        CE && change_ok;
    endsequence

    sequence seq_change_fail;
        CE && change_fail;
    endsequence

    chk_lane_rate: assert property (@(posedge CLOCK) disable iff (!ARST_N)
        LANE_RATE[LSN_SPEED_W-1:0] == STATUS.current_speed) // RULE1
        else $error("lane rate differs from current speed");

    chk_train_gen1: assert property (@(posedge CLOCK) disable iff (!ARST_N)
        CE && FULL_RETRAIN |=> STATUS.current_speed == LSN_SPEED_GEN1
            && !SPEED_CHANGE_START) // RULE2
        else $error("training did not restart at gen1");

    chk_start_in_l0: assert property (@(posedge CLOCK) disable iff (!ARST_N)
        $rose(SPEED_CHANGE_START) |-> $past(LTSSM_L0)
            && state_reg == LSN_ST_CHANGE) // RULE3
        else $error("speed change started outside L0");

    chk_no_dl_down: assert property (@(posedge CLOCK) disable iff (!ARST_N)
        CE && start_next && !FULL_RETRAIN |=> !DL_DOWN) // RULE4
        else $error("rate change raised data link down");

    chk_partner_known: assert property (@(posedge CLOCK) disable iff (!ARST_N)
        CE && start_next && speed_next == LSN_SPEED_GEN2
            |-> PARTNER_GEN2_ADV && ADV_GEN2) // RULE6
        else $error("upgrade without both sides offering gen2");

    chk_fail_revert: assert property (@(posedge CLOCK) disable iff (!ARST_N)
        seq_change_fail ##0 !FULL_RETRAIN |=> STATUS.current_speed
            == $past(STATUS.current_speed) && state_reg == LSN_ST_L0) // RULE13
        else $error("failed change altered the rate");

    chk_init_quiet: assert property (@(posedge CLOCK) disable iff (!ARST_N)
        seq_change_ok ##0 (cause_reg == LSN_CAUSE_INIT) ##0 !bw_reg
            |=> !STATUS.bw_mgmt_status) // RULE11
        else $error("initial upgrade set bandwidth status");

    chk_sw_sets_bw: assert property (@(posedge CLOCK) disable iff (!ARST_N)
        seq_change_ok ##0 (cause_reg == LSN_CAUSE_SW) ##0 !FULL_RETRAIN
            |=> STATUS.bw_mgmt_status == DOWNSTREAM_PORT) // RULE19
        else $error("software change did not set bandwidth status");

    chk_irq_gated: assert property (@(posedge CLOCK) disable iff (!ARST_N)
        BW_IRQ |-> $past(irq_en_reg) && STATUS.bw_mgmt_status) // RULE18
        else $error("interrupt while notification disabled");

    chk_status_sticky: assert property (@(posedge CLOCK) disable iff (!ARST_N)
        STATUS.bw_mgmt_status && !(CE && CFG.clr_bw_mgmt)
            |=> STATUS.bw_mgmt_status) // RULE23
        else $error("bandwidth status lost without clear");

    chk_auto_bit: assert property (@(posedge CLOCK) disable iff (!ARST_N)
        seq_change_ok ##0 (cause_reg == LSN_CAUSE_PARTNER)
            ##0 partner_auto_reg ##0 !FULL_RETRAIN
            |=> STATUS.autonomous_bw_status == DOWNSTREAM_PORT
                && !AUTONOMOUS_CHANGE) // RULE16
        else $error("partner autonomous change not flagged");

endmodule // lsn_core
`default_nettype wire

// ==== core/lsn_core_unused_placeholder_never.sv ====
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ==== test/lsn_partner_model.sv ====
`timescale 1ns/100ps
`default_nettype none
module lsn_partner_model (
    input  wire logic                clock,
    input  wire logic                arst_n,
    input  wire logic                link_up,
    input  wire logic                gen2_cap,
    input  wire logic                accept,
    input  wire logic [7:0]          delay,
    input  wire logic                start,
    input  wire logic                req_go,
    input  wire lsn_pkg::lsn_speed_t req_speed,
    input  wire logic                req_auto,
    output logic                     ltssm_l0,
    output logic                     gen2_adv,
    output logic                     req,
    output lsn_pkg::lsn_speed_t      req_spd,
    output logic                     autonomous,
    output logic                     done,
    output logic                     ok
);
    import lsn_pkg::*;
    logic [7:0] cnt_reg;
    logic       busy_reg;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            ltssm_l0   <= 1'b0;
            gen2_adv   <= 1'b0;
            req        <= 1'b0;
            req_spd    <= 4'h0;
            autonomous <= 1'b0;
            done       <= 1'b0;
            ok         <= 1'b0;
            busy_reg   <= 1'b0;
            cnt_reg    <= 8'h00;
        end else begin
            ltssm_l0   <= link_up;
            gen2_adv   <= gen2_cap;
            req        <= req_go;
            // Fields are only meaningful with the request strobe
            req_spd    <= req_go ? req_speed : ~req_spd;
            autonomous <= req_go ? req_auto : ~autonomous;
            done       <= 1'b0;
            ok         <= ~ok;
            if (start) begin
                busy_reg <= 1'b1;
                cnt_reg  <= delay;
            end else if (busy_reg && cnt_reg == 8'h00) begin
                busy_reg <= 1'b0;
                done     <= 1'b1;
                ok       <= accept;
            end else if (busy_reg) begin
                cnt_reg  <= cnt_reg - 8'h01;
            end
        end
    end
endmodule // lsn_partner_model
`default_nettype wire

// ==== test/tb_pcie_link_speed_negotiation.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_pcie_link_speed_negotiation;
    import lsn_pkg::*;
    logic        CLOCK = 1'b0;
    logic        ARST_N, FULL_RETRAIN, RELIABILITY_DOWNGRADE, CE;
    logic        LTSSM_L0, PARTNER_GEN2_ADV, PARTNER_REQ, PARTNER_AUTONOMOUS;
    logic        SPEED_CHANGE_DONE, SPEED_CHANGE_OK, SPEED_CHANGE_START;
    logic        ADV_GEN2, AUTONOMOUS_CHANGE, DL_DOWN, BW_IRQ;
    logic        link_up, gen2_cap, accept, req_go, req_auto;
    logic        fr_q = 1'b0;
    logic [7:0]  delay;
    logic [15:0] LANE_RATE;
    lsn_speed_t  PARTNER_REQ_SPEED, CHANGE_SPEED, req_speed;
    lsn_cfg_t    CFG;
    lsn_status_t STATUS;
    int          num_errors = 0;
    int          n_checks = 0;
    int          cycles = 0;
    int          n_starts = 0;
    int          n_irq = 0;
    int          n_dlbad = 0;
    int          mark;

    initial begin
        CLOCK = 1'b0;
        forever #5 CLOCK = ~CLOCK;
    end

    lsn_core #(.LANES(4), .DOWNSTREAM_PORT(1'b1)) uut (
        .CLOCK(CLOCK), .ARST_N(ARST_N), .CE(CE),
        .FULL_RETRAIN(FULL_RETRAIN), .LTSSM_L0(LTSSM_L0),
        .PARTNER_GEN2_ADV(PARTNER_GEN2_ADV), .PARTNER_REQ(PARTNER_REQ),
        .PARTNER_REQ_SPEED(PARTNER_REQ_SPEED),
        .PARTNER_AUTONOMOUS(PARTNER_AUTONOMOUS),
        .SPEED_CHANGE_DONE(SPEED_CHANGE_DONE),
        .SPEED_CHANGE_OK(SPEED_CHANGE_OK),
        .RELIABILITY_DOWNGRADE(RELIABILITY_DOWNGRADE), .CFG(CFG),
        .SPEED_CHANGE_START(SPEED_CHANGE_START), .CHANGE_SPEED(CHANGE_SPEED),
        .ADV_GEN2(ADV_GEN2), .AUTONOMOUS_CHANGE(AUTONOMOUS_CHANGE),
        .LANE_RATE(LANE_RATE), .DL_DOWN(DL_DOWN), .BW_IRQ(BW_IRQ),
        .STATUS(STATUS));

    lsn_partner_model partner (
        .clock(CLOCK), .arst_n(ARST_N), .link_up(link_up),
        .gen2_cap(gen2_cap), .accept(accept), .delay(delay),
        .start(SPEED_CHANGE_START), .req_go(req_go), .req_speed(req_speed),
        .req_auto(req_auto), .ltssm_l0(LTSSM_L0), .gen2_adv(PARTNER_GEN2_ADV),
        .req(PARTNER_REQ), .req_spd(PARTNER_REQ_SPEED),
        .autonomous(PARTNER_AUTONOMOUS), .done(SPEED_CHANGE_DONE),
        .ok(SPEED_CHANGE_OK));

    task automatic close_out();
        if (num_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Link down is only legal right after a full retrain
    always @(posedge CLOCK) begin
        cycles++;
        if (SPEED_CHANGE_START === 1'b1) n_starts++;
        if (BW_IRQ === 1'b1) n_irq++;
        if (DL_DOWN === 1'b1 && fr_q !== 1'b1) n_dlbad++;
        fr_q <= FULL_RETRAIN;
        if (cycles == 5000) begin
            num_errors++;
            close_out();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s exp %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge CLOCK);
    endtask

    task automatic wr(input lsn_speed_t t, input logic h, input logic ie);
        CFG.wr_ctrl = 1'b1;
        CFG.target_speed = t;
        CFG.hw_autonomous_speed_disable = h;
        CFG.bw_mgmt_irq_enable = ie;
        cyc(1);
        CFG.wr_ctrl = 1'b0;
        cyc(1);
    endtask

    task automatic retrain();
        CFG.retrain_request = 1'b1;
        cyc(1);
        CFG.retrain_request = 1'b0;
    endtask

    task automatic full_retrain();
        link_up = 1'b0;
        FULL_RETRAIN = 1'b1;
        cyc(1);
        FULL_RETRAIN = 1'b0;
        chk("dl_down", DL_DOWN, 1'b1);
        cyc(2);
        chk("cur_after_detect", STATUS.current_speed, LSN_SPEED_GEN1);
        link_up = 1'b1;
    endtask

    task automatic partner_req(input lsn_speed_t sp, input logic au);
        req_speed = sp;
        req_auto = au;
        req_go = 1'b1;
        cyc(1);
        req_go = 1'b0;
    endtask

    task automatic wait_start(input lsn_speed_t sp);
        for (int i = 0; i < 50 && SPEED_CHANGE_START !== 1'b1; i++) cyc(1);
        chk("start", SPEED_CHANGE_START, 1'b1);
        chk("change_speed", CHANGE_SPEED, sp);
        cyc(1);
    endtask

    task automatic wait_cur(input lsn_speed_t sp);
        for (int i = 0; i < 60 && STATUS.current_speed !== sp; i++) cyc(1);
        chk("current_speed", STATUS.current_speed, sp);
        chk("lane_rate", LANE_RATE, {4{sp}});
    endtask

    task automatic t_reset();
        chk("cur_rst", STATUS.current_speed, LSN_SPEED_GEN1);
        chk("tgt_rst", STATUS.target_speed, LSN_SPEED_GEN2);
        chk("adv_rst", ADV_GEN2, 1'b1);
        chk("auto_bit", AUTONOMOUS_CHANGE, 1'b0);
        chk("lanes_rst", LANE_RATE, 16'h1111);
        chk("bw_rst", {STATUS.bw_mgmt_status, STATUS.autonomous_bw_status},
            2'b00);
    endtask

    task automatic t_initial();
        wr(LSN_SPEED_GEN2, 1'b1, 1'b0);
        chk("hw_autonomous_speed_disable", STATUS.hw_autonomous_speed_disable, 1'b1);
        cyc(5);
        chk("no_start_pre_l0", n_starts, 0);
        gen2_cap = 1'b1;
        link_up = 1'b1;
        wait_start(LSN_SPEED_GEN2);
        wait_cur(LSN_SPEED_GEN2);
        chk("bw_initial", STATUS.bw_mgmt_status, 1'b0);
        chk("no_dl_down", n_dlbad, 0);
    endtask

    task automatic t_sw_down();
        wr(LSN_SPEED_GEN1, 1'b1, 1'b1);
        retrain();
        wait_start(LSN_SPEED_GEN1);
        wait_cur(LSN_SPEED_GEN1);
        chk("bw_sw", STATUS.bw_mgmt_status, 1'b1);
        chk("irq_sw", BW_IRQ, 1'b1);
        chk("irq_en", STATUS.bw_mgmt_irq_enable, 1'b1);
        cyc(4);
        chk("irq_once", n_irq, 1);
        chk("bw_sticky", STATUS.bw_mgmt_status, 1'b1);
        // Clear with the clock enable low must not take effect
        CE = 1'b0;
        CFG.clr_bw_mgmt = 1'b1;
        cyc(1);
        chk("bw_frozen", STATUS.bw_mgmt_status, 1'b1);
        CE = 1'b1;
        cyc(1);
        CFG.clr_bw_mgmt = 1'b0;
        cyc(1);
        chk("bw_clear", STATUS.bw_mgmt_status, 1'b0);
    endtask

    task automatic t_fail_then_honour();
        wr(LSN_SPEED_GEN2, 1'b0, 1'b0);
        accept = 1'b0;
        full_retrain();
        wait_start(LSN_SPEED_GEN2);
        cyc(10);
        mark = n_starts;
        cyc(30);
        chk("cur_failed", STATUS.current_speed, LSN_SPEED_GEN1);
        chk("no_retry", n_starts, mark);
        accept = 1'b1;
        retrain();
        wait_start(LSN_SPEED_GEN2);
        wait_cur(LSN_SPEED_GEN2);
        chk("bw_retrain", STATUS.bw_mgmt_status, 1'b1);
        chk("irq_masked", n_irq, 1);
        partner_req(LSN_SPEED_GEN1, 1'b1);
        wait_start(LSN_SPEED_GEN1);
        wait_cur(LSN_SPEED_GEN1);
        chk("abw_set", STATUS.autonomous_bw_status, 1'b1);
        partner_req(LSN_SPEED_GEN2, 1'b0);
        wait_start(LSN_SPEED_GEN2);
        wait_cur(LSN_SPEED_GEN2);
    endtask

    task automatic t_reliability();
        CFG.clr_bw_mgmt = 1'b1;
        CFG.clr_autonomous_bw = 1'b1;
        cyc(1);
        CFG.clr_bw_mgmt = 1'b0;
        CFG.clr_autonomous_bw = 1'b0;
        RELIABILITY_DOWNGRADE = 1'b1;
        cyc(1);
        RELIABILITY_DOWNGRADE = 1'b0;
        wait_start(LSN_SPEED_GEN1);
        wait_cur(LSN_SPEED_GEN1);
        chk("bw_reliab", STATUS.bw_mgmt_status, 1'b1);
        chk("adv_withdrawn", ADV_GEN2, 1'b0);
        chk("abw_clear", STATUS.autonomous_bw_status, 1'b0);
    endtask

    task automatic t_one_side();
        gen2_cap = 1'b0;
        full_retrain();
        mark = n_starts;
        cyc(30);
        chk("adv_again", ADV_GEN2, 1'b1);
        chk("stay_gen1", n_starts, mark);
        wait_cur(LSN_SPEED_GEN1);
        chk("no_dl_down_end", n_dlbad, 0);
    endtask

    initial begin
        ARST_N = 1'b0;
        FULL_RETRAIN = 1'b0;
        RELIABILITY_DOWNGRADE = 1'b0;
        CFG = '0;
        link_up = 1'b0;
        gen2_cap = 1'b0;
        accept = 1'b1;
        delay = 8'h04;
        req_go = 1'b0;
        req_speed = LSN_SPEED_GEN1;
        req_auto = 1'b0;
        CE = 1'b1;
        cyc(3);
        ARST_N = 1'b1;
        cyc(1);
        t_reset();
        t_initial();
        t_sw_down();
        t_fail_then_honour();
        t_reliability();
        t_one_side();
        close_out();
    end
endmodule // tb_pcie_link_speed_negotiation
`default_nettype wire
